// ---- hw/gpd_pkg.sv ----
// constants for the twelve-pin general purpose port
// assumes an aligned 32-bit register bus
package gpd_pkg;
    localparam int unsigned NUM_PINS = 12;
    localparam logic [11:0] OFS_CFG = 12'h1_e0;
    localparam logic [11:0] OFS_DATA_DIR = 12'h1_e4;
    localparam int unsigned DATA_LSB = 0;
    localparam int unsigned DIR_LSB = 16;
    localparam int unsigned BUF_LSB = 0;
    localparam int unsigned POL8_BIT = 12;
    localparam int unsigned POL9_BIT = 13;
    localparam int unsigned EVOE_LSB = 14;
    localparam logic [11:0] RST_DATA = 12'h0_00;
    localparam logic [11:0] RST_DIR = 12'h0_00;
    localparam logic [11:0] RST_BUF = 12'h0_00;
    localparam logic [1:0] RST_EVOE = 2'h0;
    localparam logic [1:0] RST_POL = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpd_pkg

// ---- hw/gpd_pin_drive.sv ----
// output driver for one pin: direction, buffer type, event override
// assumes data, event and controls are registered upstream
`timescale 1ns/10ps
module gpd_pin_drive (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic dir,
    input wire logic push_pull,
    input wire logic data,
    input wire logic ev_en,
    input wire logic ev_pol,
    input wire logic ev_active,
    output logic pin_o,
    output logic pin_oe
);
    logic drive_en;
    logic level;
    always_comb begin
        drive_en = ev_en | dir; // [R8] [R9] [R10]
        level = ev_en ? (ev_active ~^ ev_pol) : data; // [R11]
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_o <= level; // [R5]
            // open drain drives low only, push/pull both ways
            pin_oe <= drive_en & (push_pull | ~level); // [R1] [R2] [R3]
        end
    end
    property p_od_high_float;
        @(posedge aclk) disable iff (!aresetn)
        (!push_pull && level) |=> !pin_oe;
    endproperty
    a_od_high_float: assert property (p_od_high_float) // [R2]
        else $error("open drain drove a high level");

    property p_pp_drive;
        @(posedge aclk) disable iff (!aresetn)
        (drive_en && push_pull) |=> (pin_oe && pin_o == $past(level));
    endproperty
    a_pp_drive: assert property (p_pp_drive) // [R1]
        else $error("push/pull pin not driven both ways");
endmodule : gpd_pin_drive

// ---- hw/gpd_axil_slave.sv ----
// axi4-lite slave front end: one write and one read in flight
// assumes the register store answers combinationally on rd_data
`timescale 1ns/10ps
module gpd_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [11:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_have_q;
    logic w_have_q;
    logic rd_busy_q;
    always_comb begin
        wr_en = aw_have_q & w_have_q & ~s_axi_bvalid;
        rd_addr = s_axi_araddr;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_addr <= 12'h0_00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpd_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? gpd_pkg::RESP_OKAY
                                     : gpd_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_busy_q <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= gpd_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~rd_busy_q & ~s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_busy_q <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? gpd_pkg::RESP_OKAY
                                     : gpd_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rd_busy_q <= 1'b0;
            end
        end
    end
endmodule : gpd_axil_slave

// ---- hw/gpd_top.sv ----
// twelve-pin general purpose port with event outputs on pins 8 and 9
// assumes pin inputs and event inputs synchronous to aclk
//
// Behaviour
// R1: buffer bit 0 open drain, 1 push/pull
// R2: open drain pulls low on 0, floats on 1
// R3: event pins open drain follow polarity for drive
// R4: direction bits 27:16, 1 means output
// R5: output pin drives last written data bit
// R6: input pin read returns sampled pin level
// R7: output pin read returns last written value
// R8: pins 11-10, 7-0 direction from direction bits
// R9: pins 9, 8 direction also from event enable
// R10: event enable forces event output, keeps buffer type
// R11: event polarity 0 active low, resets to 1
// R12: reserved data/direction bits read zero, ignore writes
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module gpd_top (
    aclk,
    aresetn,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    pin_i,
    pin_o,
    pin_oe,
    clock_event
);
    input wire logic aclk;
    input wire logic aresetn;
    input wire logic [11:0] s_axi_awaddr;
    input wire logic s_axi_awvalid;
    output logic s_axi_awready;
    input wire logic [31:0] s_axi_wdata;
    input wire logic [3:0] s_axi_wstrb;
    input wire logic s_axi_wvalid;
    output logic s_axi_wready;
    output logic [1:0] s_axi_bresp;
    output logic s_axi_bvalid;
    input wire logic s_axi_bready;
    input wire logic [11:0] s_axi_araddr;
    input wire logic s_axi_arvalid;
    output logic s_axi_arready;
    output logic [31:0] s_axi_rdata;
    output logic [1:0] s_axi_rresp;
    output logic s_axi_rvalid;
    input wire logic s_axi_rready;
    input wire logic [11:0] pin_i;
    output logic [11:0] pin_o;
    output logic [11:0] pin_oe;
    input wire logic [1:0] clock_event;

    logic [11:0] pin_data_bits_q;
    logic [11:0] pin_direction_bits_q;
    logic [11:0] pin_buffer_type_q;
    logic [1:0] event_oe_q;
    logic event_polarity_pin8_q;
    logic event_polarity_pin9_q;
    logic [11:0] pin_level_q;
    logic [1:0] event_q;
    logic [11:0] eff_dir;
    logic [11:0] ev_en_vec;
    logic [11:0] ev_pol_vec;
    logic [11:0] ev_act_vec;
    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [31:0] cfg_word;
    logic [31:0] dd_word;
    logic [31:0] wmask;

    gpd_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // byte enables to bit mask
    always_comb begin
        wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                 {8{wr_strb[1]}}, {8{wr_strb[0]}}};
        wr_ok = (wr_addr == gpd_pkg::OFS_CFG) ||
                (wr_addr == gpd_pkg::OFS_DATA_DIR);
        rd_ok = (rd_addr == gpd_pkg::OFS_CFG) ||
                (rd_addr == gpd_pkg::OFS_DATA_DIR);
    end

    // data and direction register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_data_bits_q <= gpd_pkg::RST_DATA;
            pin_direction_bits_q <= gpd_pkg::RST_DIR;
        end else if (wr_en && wr_addr == gpd_pkg::OFS_DATA_DIR) begin
            for (int i = 0; i < 12; i++) begin
                if (wmask[gpd_pkg::DATA_LSB + i]) begin
                    pin_data_bits_q[i] <=
                        wr_data[gpd_pkg::DATA_LSB + i]; // [R5] [R7]
                end
                if (wmask[gpd_pkg::DIR_LSB + i]) begin
                    pin_direction_bits_q[i] <=
                        wr_data[gpd_pkg::DIR_LSB + i]; // [R4]
                end
            end
        end
    end

    // configuration register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_buffer_type_q <= gpd_pkg::RST_BUF;
            event_oe_q <= gpd_pkg::RST_EVOE;
            event_polarity_pin8_q <= gpd_pkg::RST_POL[0]; // [R11]
            event_polarity_pin9_q <= gpd_pkg::RST_POL[1]; // [R11]
        end else if (wr_en && wr_addr == gpd_pkg::OFS_CFG) begin
            for (int i = 0; i < 12; i++) begin
                if (wmask[gpd_pkg::BUF_LSB + i]) begin
                    pin_buffer_type_q[i] <=
                        wr_data[gpd_pkg::BUF_LSB + i]; // [R1]
                end
            end
            if (wmask[gpd_pkg::POL8_BIT]) begin
                event_polarity_pin8_q <= wr_data[gpd_pkg::POL8_BIT];
            end
            if (wmask[gpd_pkg::POL9_BIT]) begin
                event_polarity_pin9_q <= wr_data[gpd_pkg::POL9_BIT];
            end
            if (wmask[gpd_pkg::EVOE_LSB + 1]) begin
                event_oe_q <= wr_data[gpd_pkg::EVOE_LSB +: 2]; // [R10]
            end
        end
    end

    // input sampling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_level_q <= 12'h0_00;
            event_q <= 2'h0;
        end else begin
            pin_level_q <= pin_i; // [R6]
            event_q <= clock_event;
        end
    end

    // event override applies to pins 8 and 9 only
    always_comb begin
        ev_en_vec = {2'h0, event_oe_q, 8'h00}; // [R8] [R9]
        ev_pol_vec = {2'h0, event_polarity_pin9_q,
                      event_polarity_pin8_q, 8'h00};
        ev_act_vec = {2'h0, event_q, 8'h00};
        eff_dir = pin_direction_bits_q | ev_en_vec; // [R9] [R10]
    end

    // read-back word
    always_comb begin
        dd_word = 32'h0000_0000; // [R12]
        for (int i = 0; i < 12; i++) begin
            dd_word[gpd_pkg::DATA_LSB + i] = eff_dir[i] ?
                pin_data_bits_q[i] : pin_level_q[i]; // [R6] [R7]
            dd_word[gpd_pkg::DIR_LSB + i] = pin_direction_bits_q[i];
        end
        cfg_word = 32'h0000_0000;
        cfg_word[gpd_pkg::BUF_LSB +: 12] = pin_buffer_type_q;
        cfg_word[gpd_pkg::POL8_BIT] = event_polarity_pin8_q;
        cfg_word[gpd_pkg::POL9_BIT] = event_polarity_pin9_q;
        cfg_word[gpd_pkg::EVOE_LSB +: 2] = event_oe_q;
        if (rd_addr == gpd_pkg::OFS_DATA_DIR) begin
            rd_data = dd_word;
        end else if (rd_addr == gpd_pkg::OFS_CFG) begin
            rd_data = cfg_word;
        end else begin
            rd_data = 32'h0000_0000;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 12; g++) begin : g_pin
            gpd_pin_drive u_drv (
                .aclk(aclk),
                .aresetn(aresetn),
                .dir(pin_direction_bits_q[g]),
                .push_pull(pin_buffer_type_q[g]),
                .data(pin_data_bits_q[g]),
                .ev_en(ev_en_vec[g]),
                .ev_pol(ev_pol_vec[g]),
                .ev_active(ev_act_vec[g]),
                .pin_o(pin_o[g]),
                .pin_oe(pin_oe[g])
            );
        end
    endgenerate

    property p_out_follows_data;
        @(posedge aclk) disable iff (!aresetn)
        (pin_direction_bits_q[0] && pin_buffer_type_q[0])
            |=> (pin_oe[0] && pin_o[0] == $past(pin_data_bits_q[0]));
    endproperty
    a_out_follows_data: assert property (p_out_follows_data) // [R5]
        else $error("output pin does not follow data bit");

    property p_input_undriven;
        @(posedge aclk) disable iff (!aresetn)
        (!pin_direction_bits_q[3]) |=> !pin_oe[3];
    endproperty
    a_input_undriven: assert property (p_input_undriven) // [R4] [R8]
        else $error("input pin is driven");

    property p_od_low;
        @(posedge aclk) disable iff (!aresetn)
        (pin_direction_bits_q[1] && !pin_buffer_type_q[1]
            && !pin_data_bits_q[1]) |=> (pin_oe[1] && !pin_o[1]);
    endproperty
    a_od_low: assert property (p_od_low) // [R2]
        else $error("open drain low not driven");

    property p_od_float;
        @(posedge aclk) disable iff (!aresetn)
        (!pin_buffer_type_q[2] && pin_data_bits_q[2]
            && pin_direction_bits_q[2]) |=> !pin_oe[2];
    endproperty
    a_od_float: assert property (p_od_float) // [R1] [R2]
        else $error("open drain high was driven");

    property p_ev_force;
        @(posedge aclk) disable iff (!aresetn)
        (event_oe_q[0] && pin_buffer_type_q[8]) |=> pin_oe[8];
    endproperty
    a_ev_force: assert property (p_ev_force) // [R10]
        else $error("event enable did not force output");

    property p_ev_od_idle;
        @(posedge aclk) disable iff (!aresetn)
        (event_oe_q[1] && !pin_buffer_type_q[9] && !event_polarity_pin9_q
            && !event_q[1]) |=> !pin_oe[9];
    endproperty
    a_ev_od_idle: assert property (p_ev_od_idle) // [R3] [R11]
        else $error("idle low-polarity event pin driven");

    property p_read_input;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr ==
            gpd_pkg::OFS_DATA_DIR && !eff_dir[4])
            |=> (s_axi_rdata[4] == $past(pin_level_q[4]));
    endproperty
    a_read_input: assert property (p_read_input) // [R6]
        else $error("input read-back wrong");

    property p_read_output;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr ==
            gpd_pkg::OFS_DATA_DIR && eff_dir[5])
            |=> (s_axi_rdata[5] == $past(pin_data_bits_q[5]));
    endproperty
    a_read_output: assert property (p_read_output) // [R7] [R8]
        else $error("output read-back wrong");

    property p_reserved_zero;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr ==
            gpd_pkg::OFS_DATA_DIR) |=> (s_axi_rdata[31:28] == 4'h0
            && s_axi_rdata[15:12] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [R12]
        else $error("reserved bits not zero");
endmodule : gpd_top

// ---- testbench/gpd_pin_model.sv ----
// board side of the twelve pins: device drive, external drive, pull-up
// assumes external drive only on pins the device has released
`timescale 1ns/10ps
module gpd_pin_model (
    input wire logic [11:0] pin_o,
    input wire logic [11:0] pin_oe,
    input wire logic [11:0] ext_val,
    input wire logic [11:0] ext_en,
    output logic [11:0] pin_i
);
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (pin_oe[i]) begin
                pin_i[i] = pin_o[i];
            end else if (ext_en[i]) begin
                pin_i[i] = ext_val[i];
            end else begin
                pin_i[i] = 1'b1; // released line pulled up
            end
        end
    end
endmodule : gpd_pin_model

// ---- testbench/tb_gpd_top.sv ----
// self-checking bench for the twelve-pin port
// assumes axi4-lite master at 20 MHz and a pulled-up pin board
`timescale 1ns/10ps
module tb_gpd_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [11:0] pin_i, pin_o, pin_oe;
    logic [11:0] ext_val = 12'h000, ext_en = 12'h000;
    logic [1:0] clock_event = 2'h0;
    logic [1:0] bq[$], rrq[$];
    logic [31:0] rdq[$];
    logic [31:0] seed, d, cw, rx;
    logic [11:0] bufm;
    logic [1:0] lvl, oe;
    int bad_count = 0, checks_done = 0;

    always #25 aclk = ~aclk;

    gpd_top dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .clock_event(clock_event));

    gpd_pin_model board_u (.pin_o(pin_o), .pin_oe(pin_oe),
        .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic complete_run;
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic [1:0] r);
        logic ta, tw, tb, done;
        done = 1'b0;
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64 && !done; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) bad_count++;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] v,
                      input logic [1:0] r);
        logic ta, tr, done;
        done = 1'b0;
        rdq.push_back(v);
        rrq.push_back(r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64 && !done; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) bad_count++;
    endtask : rd

    task automatic pins(input logic [11:0] e_oe, input logic [11:0] e_o);
        repeat (2) @(negedge aclk);
        chk("pin_oe", 32'(pin_oe), 32'(e_oe));
        chk("pin_o", 32'(pin_o & pin_oe), 32'(e_o & e_oe));
    endtask : pins

    // response monitor: oldest note against each answer
    always @(posedge aclk) begin
        if (bvalid && bready) begin
            chk("bresp", 32'(bresp), 32'(bq.pop_front()));
        end
        if (rvalid && rready) begin
            chk("rdata", rdata, rdq.pop_front());
            chk("rresp", 32'(rresp), 32'(rrq.pop_front()));
        end
    end

    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        complete_run;
    end

    initial begin
        seed = 32'h37b9_0947;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(gpd_pkg::OFS_CFG, 32'h0000_3000, gpd_pkg::RESP_OKAY);
        rd(gpd_pkg::OFS_DATA_DIR, 32'h0000_0fff, gpd_pkg::RESP_OKAY);
        pins(12'h000, 12'h000);
        // random data, direction, reserved bits; buffer type alternates open drain and push/pull
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            d = seed;
            seed = xs(seed);
            ext_val <= seed[11:0];
            ext_en <= ~d[27:16];
            bufm = k[0] ? 12'hfff : 12'h000;
            wr(gpd_pkg::OFS_CFG, {20'h0_0003, bufm}, gpd_pkg::RESP_OKAY);
            wr(gpd_pkg::OFS_DATA_DIR, d, gpd_pkg::RESP_OKAY);
            rx = {4'h0, d[27:16], 4'h0,
                  (d[11:0] & d[27:16]) | (seed[11:0] & ~d[27:16])};
            rd(gpd_pkg::OFS_DATA_DIR, rx, gpd_pkg::RESP_OKAY);
            pins(k[0] ? d[27:16] : d[27:16] & ~d[11:0], d[11:0]);
        end
        // event outputs on pins 8 and 9, every polarity and event level
        wr(gpd_pkg::OFS_DATA_DIR, 32'h0000_0000, gpd_pkg::RESP_OKAY);
        ext_en <= 12'hcff;
        for (int j = 0; j < 32; j++) begin
            bufm = j[4] ? 12'hfff : 12'h000;
            clock_event <= j[3:2];
            cw = {16'h0000, 2'b11, j[1:0], bufm};
            wr(gpd_pkg::OFS_CFG, cw, gpd_pkg::RESP_OKAY);
            rd(gpd_pkg::OFS_CFG, cw, gpd_pkg::RESP_OKAY);
            lvl = ~(j[3:2] ^ j[1:0]);
            oe = j[4] ? 2'b11 : ~lvl;
            pins({2'b00, oe, 8'h00}, {2'b00, lvl, 8'h00});
        end
        rx = {20'h0_0000, seed[11:0] & 12'hcff};
        rd(gpd_pkg::OFS_DATA_DIR, rx, gpd_pkg::RESP_OKAY);
        wr(gpd_pkg::OFS_CFG, 32'h0000_3fff, gpd_pkg::RESP_OKAY);
        wstrb <= 4'h1;
        pins(12'h000, 12'h000);
        // lane 0 only: event enable and polarity keep their values
        wr(gpd_pkg::OFS_CFG, 32'h0000_c000, gpd_pkg::RESP_OKAY);
        rd(gpd_pkg::OFS_CFG, 32'h0000_3f00, gpd_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        wr(12'h1_e8, 32'hffff_ffff, gpd_pkg::RESP_SLVERR);
        rd(12'h1_e8, 32'h0000_0000, gpd_pkg::RESP_SLVERR);
        complete_run;
    end
endmodule : tb_gpd_top
